// file: rtl/asc_pkg.sv
package asc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets on the special-register port
  localparam logic [7:0] ASC_OFS_RES_LOW = 8'h24;
  localparam logic [7:0] ASC_OFS_RES_HIGH = 8'h25;
  localparam logic [7:0] ASC_OFS_CTRL = 8'h26;
  localparam logic [7:0] ASC_OFS_CLKSEL = 8'h27;
  localparam logic [7:0] ASC_OFS_INT_STATUS = 8'h28;
  localparam logic [7:0] ASC_OFS_INT_MASK = 8'h29;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int ASC_CTRL_START_BIT = 7;
  localparam int ASC_CTRL_PEND_BIT = 6;
  localparam int ASC_CTRL_CFG_LSB = 3;
  localparam int ASC_CTRL_CHAN_LSB = 0;
  localparam int ASC_CLKSEL_TEST_BIT = 7;
  localparam int ASC_CLKSEL_DIV_LSB = 0;
  localparam int ASC_INT_DONE_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0] ASC_CTRL_RST = 8'h00;
  localparam logic [7:0] ASC_CLKSEL_RST = 8'h00;
  localparam logic [7:0] ASC_RES_RST = 8'h00;
  localparam logic [7:0] ASC_INT_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // conversion clock divider: select codes and terminal counts
  localparam logic [1:0] ASC_SEL_DIV2 = 2'h0;
  localparam logic [1:0] ASC_SEL_DIV8 = 2'h1;
  localparam logic [1:0] ASC_SEL_DIV32 = 2'h2;
  localparam logic [4:0] ASC_TC_DIV2 = 5'h01;
  localparam logic [4:0] ASC_TC_DIV8 = 5'h07;
  localparam logic [4:0] ASC_TC_DIV32 = 5'h1F;
  localparam logic [4:0] ASC_TC_UNDEF = 5'h1F;

  ////////////////////////////////////////////////////////////////////////////
  // conversion timing in conversion clock periods
  localparam logic [3:0] ASC_SAMPLE_TICKS = 4'h4;
  localparam logic [3:0] ASC_TRIAL_TICKS = 4'h4;
  localparam int ASC_RES_BITS = 10;

  // successive approximation sequencer states
  typedef enum logic [1:0] {
    ASC_IDLE,
    ASC_SAMPLE,
    ASC_TRIAL
  } asc_state_t;

endpackage

// file: rtl/asc_sar_engine.sv
`timescale 1ns/1ps
module asc_sar_engine #(
  parameter int RES_BITS = asc_pkg::ASC_RES_BITS,
  parameter logic [3:0] SAMPLE_TICKS = asc_pkg::ASC_SAMPLE_TICKS,
  parameter logic [3:0] TRIAL_TICKS = asc_pkg::ASC_TRIAL_TICKS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic convTick,
  input wire logic convReset,
  input wire logic launch,
  input wire logic powerOn,
  input wire logic compHigh,
  output logic busy,
  output logic done,
  output logic [RES_BITS-1:0] result,
  output logic [RES_BITS-1:0] trialCode
);

  asc_pkg::asc_state_t state_ff, nxt_state;
  logic [3:0] tickCnt_ff, nxt_tickCnt;
  logic [3:0] bitIdx_ff, nxt_bitIdx;
  logic [RES_BITS-1:0] trial_ff, nxt_trial;
  logic [RES_BITS-1:0] result_ff, nxt_result;
  logic done_ff, nxt_done;

  ////////////////////////////////////////////////////////////////////////////
  // sample, then one trial per bit from msb down
  always_comb begin
    nxt_state = state_ff;
    nxt_tickCnt = tickCnt_ff;
    nxt_bitIdx = bitIdx_ff;
    nxt_trial = trial_ff;
    nxt_result = result_ff;
    nxt_done = 1'b0;
    if (convReset || !powerOn) begin
      nxt_state = asc_pkg::ASC_IDLE;
      nxt_tickCnt = 4'h0;
      nxt_trial = '0;
    end else begin
      case (state_ff)
        asc_pkg::ASC_IDLE: begin
          if (launch) begin
            nxt_state = asc_pkg::ASC_SAMPLE;
            nxt_tickCnt = 4'h0;
            nxt_trial = '0;
          end
        end
        asc_pkg::ASC_SAMPLE: begin
          if (convTick) begin
            if (tickCnt_ff == SAMPLE_TICKS - 4'h1) begin
              nxt_state = asc_pkg::ASC_TRIAL;
              nxt_tickCnt = 4'h0;
              nxt_bitIdx = 4'(RES_BITS - 1);
              nxt_trial = '0;
              nxt_trial[RES_BITS-1] = 1'b1;
            end else begin
              nxt_tickCnt = tickCnt_ff + 4'h1;
            end
          end
        end
        asc_pkg::ASC_TRIAL: begin
          if (convTick) begin
            if (tickCnt_ff == TRIAL_TICKS - 4'h1) begin
              nxt_tickCnt = 4'h0;
              // drop the trial bit when the input sits below the dac
              if (!compHigh) begin
                nxt_trial[bitIdx_ff] = 1'b0;
              end
              if (bitIdx_ff == 4'h0) begin
                nxt_result = nxt_trial;
                nxt_done = 1'b1;
                nxt_state = asc_pkg::ASC_IDLE;
              end else begin
                nxt_bitIdx = bitIdx_ff - 4'h1;
                nxt_trial[bitIdx_ff - 4'h1] = 1'b1;
              end
            end else begin
              nxt_tickCnt = tickCnt_ff + 4'h1;
            end
          end
        end
        default: begin
          nxt_state = asc_pkg::ASC_IDLE;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= asc_pkg::ASC_IDLE;
      tickCnt_ff <= 4'h0;
      bitIdx_ff <= 4'h0;
      trial_ff <= '0;
      result_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tickCnt_ff <= nxt_tickCnt;
      bitIdx_ff <= nxt_bitIdx;
      trial_ff <= nxt_trial;
      result_ff <= nxt_result;
      done_ff <= nxt_done;
    end
  end

  // status and data out
  assign busy = (state_ff != asc_pkg::ASC_IDLE);
  assign done = done_ff;
  assign result = result_ff;
  assign trialCode = trial_ff;

endmodule

// file: rtl/asc_top.sv
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module asc_top #(
  parameter int RES_BITS = asc_pkg::ASC_RES_BITS,
  parameter logic [3:0] SAMPLE_TICKS = asc_pkg::ASC_SAMPLE_TICKS,
  parameter logic [3:0] TRIAL_TICKS = asc_pkg::ASC_TRIAL_TICKS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic compIn,
  output logic [7:0] portBAnalog,
  output logic [2:0] analogChannel,
  output logic converterPowerOn,
  output logic [RES_BITS-1:0] dacCode,
  output logic convIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic compS1_ff, compS2_ff, compS3_ff, compLevel_ff;
  logic nxt_compS1, nxt_compS2, nxt_compS3, nxt_compLevel;
  logic [4:0] divCnt_ff, nxt_divCnt;
  logic [4:0] divLimit;
  logic convTick;
  logic [2:0] cfg_ff, nxt_cfg;
  logic [2:0] chan_ff, nxt_chan;
  logic start_ff, nxt_start;
  logic pending_ff, nxt_pending;
  logic [1:0] clkSel_ff, nxt_clkSel;
  logic clkTest_ff, nxt_clkTest;
  logic intStatus_ff, nxt_intStatus;
  logic intMask_ff, nxt_intMask;
  logic [7:0] resLow_ff, nxt_resLow;
  logic [7:0] resHigh_ff, nxt_resHigh;
  logic [7:0] portB_ff, nxt_portB;
  logic [2:0] chanOut_ff, nxt_chanOut;
  logic powerOn_ff, nxt_powerOn;
  logic irq_ff, nxt_irq;
  logic [7:0] rdData_ff, nxt_rdData;
  logic wrCtrl, wrClkSel, wrStatus, wrMask;
  logic startRise, startFall;
  logic engBusy, engDone;
  logic [RES_BITS-1:0] engResult;
  logic [RES_BITS-1:0] engTrial;
  logic [3:0] selAge_ff, nxt_selAge;

  // pins handed to the converter for each config code
  function automatic logic [7:0] pinMap(input logic [2:0] cfg);
    logic [7:0] m;
    m = 8'h00;
    case (cfg)
      3'h0: m = 8'h00;
      3'h1: m = 8'h01;
      3'h2: m = 8'h03;
      3'h3: m = 8'h07;
      3'h4: m = 8'h0F;
      3'h5: m = 8'h1F;
      3'h6: m = 8'h3F;
      3'h7: m = 8'hFF;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // comparator synchroniser, level taken once stages two and three agree
  always_comb begin
    nxt_compS1 = compIn;
    nxt_compS2 = compS1_ff;
    nxt_compS3 = compS2_ff;
    nxt_compLevel = (compS2_ff == compS3_ff) ? compS3_ff : compLevel_ff;
  end

  // synchroniser registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      compS1_ff <= 1'b0;
      compS2_ff <= 1'b0;
      compS3_ff <= 1'b0;
      compLevel_ff <= 1'b0;
    end else begin
      compS1_ff <= nxt_compS1;
      compS2_ff <= nxt_compS2;
      compS3_ff <= nxt_compS3;
      compLevel_ff <= nxt_compLevel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion clock divider, one tick per conversion clock period
  always_comb begin
    case (clkSel_ff)
      asc_pkg::ASC_SEL_DIV2: divLimit = asc_pkg::ASC_TC_DIV2;
      asc_pkg::ASC_SEL_DIV8: divLimit = asc_pkg::ASC_TC_DIV8;
      asc_pkg::ASC_SEL_DIV32: divLimit = asc_pkg::ASC_TC_DIV32;
      default: divLimit = asc_pkg::ASC_TC_UNDEF;
    endcase
    // compare with >= so a smaller divisor never waits for a wrap
    convTick = (divCnt_ff >= divLimit);
    nxt_divCnt = convTick ? 5'h00 : divCnt_ff + 5'h01;
  end

  // divider register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_ff <= 5'h00;
    end else begin
      divCnt_ff <= nxt_divCnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write decode and start edge detection
  assign wrCtrl = regWrEn && (regAddr == asc_pkg::ASC_OFS_CTRL);
  assign wrClkSel = regWrEn && (regAddr == asc_pkg::ASC_OFS_CLKSEL);
  assign wrStatus = regWrEn && (regAddr == asc_pkg::ASC_OFS_INT_STATUS);
  assign wrMask = regWrEn && (regAddr == asc_pkg::ASC_OFS_INT_MASK);
  assign startRise = wrCtrl && regWrData[asc_pkg::ASC_CTRL_START_BIT] && !start_ff;
  assign startFall = wrCtrl && !regWrData[asc_pkg::ASC_CTRL_START_BIT] && start_ff;

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  asc_sar_engine #(
    .RES_BITS(RES_BITS),
    .SAMPLE_TICKS(SAMPLE_TICKS),
    .TRIAL_TICKS(TRIAL_TICKS)
  ) u_engine (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .convTick(convTick),
    .convReset(startRise),
    .launch(startFall),
    .powerOn(powerOn_ff),
    .compHigh(compLevel_ff),
    .busy(engBusy),
    .done(engDone),
    .result(engResult),
    .trialCode(engTrial)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register file next values
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_chan = chan_ff;
    nxt_start = start_ff;
    nxt_clkSel = clkSel_ff;
    nxt_clkTest = clkTest_ff;
    nxt_intMask = intMask_ff;
    nxt_resLow = resLow_ff;
    nxt_resHigh = resHigh_ff;
    if (wrCtrl) begin
      nxt_cfg = regWrData[asc_pkg::ASC_CTRL_CFG_LSB +: 3];
      nxt_chan = regWrData[asc_pkg::ASC_CTRL_CHAN_LSB +: 3];
      nxt_start = regWrData[asc_pkg::ASC_CTRL_START_BIT];
    end
    if (wrClkSel) begin
      nxt_clkSel = regWrData[asc_pkg::ASC_CLKSEL_DIV_LSB +: 2];
      nxt_clkTest = regWrData[asc_pkg::ASC_CLKSEL_TEST_BIT];
    end
    if (wrMask) begin
      nxt_intMask = regWrData[asc_pkg::ASC_INT_DONE_BIT];
    end
    // pending: a start rise wins over an end in the same cycle
    if (startRise) begin
      nxt_pending = 1'b1;
    end else if (engDone) begin
      nxt_pending = 1'b0;
    end else begin
      nxt_pending = pending_ff;
    end
    // sticky done flag, write one clears, a new end wins
    nxt_intStatus = intStatus_ff;
    if (wrStatus && regWrData[asc_pkg::ASC_INT_DONE_BIT]) begin
      nxt_intStatus = 1'b0;
    end
    if (engDone) begin
      nxt_intStatus = 1'b1;
    end
    // left justified result capture, held until the next end
    if (engDone) begin
      nxt_resHigh = engResult[RES_BITS-1:2];
      nxt_resLow = {engResult[1:0], 6'h00};
    end
  end

  // register file
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= asc_pkg::ASC_CTRL_RST[asc_pkg::ASC_CTRL_CFG_LSB +: 3];
      chan_ff <= asc_pkg::ASC_CTRL_RST[asc_pkg::ASC_CTRL_CHAN_LSB +: 3];
      start_ff <= asc_pkg::ASC_CTRL_RST[asc_pkg::ASC_CTRL_START_BIT];
      pending_ff <= asc_pkg::ASC_CTRL_RST[asc_pkg::ASC_CTRL_PEND_BIT];
      clkSel_ff <= asc_pkg::ASC_CLKSEL_RST[asc_pkg::ASC_CLKSEL_DIV_LSB +: 2];
      clkTest_ff <= asc_pkg::ASC_CLKSEL_RST[asc_pkg::ASC_CLKSEL_TEST_BIT];
      intStatus_ff <= asc_pkg::ASC_INT_RST[asc_pkg::ASC_INT_DONE_BIT];
      intMask_ff <= asc_pkg::ASC_INT_RST[asc_pkg::ASC_INT_DONE_BIT];
      resLow_ff <= asc_pkg::ASC_RES_RST;
      resHigh_ff <= asc_pkg::ASC_RES_RST;
    end else begin
      cfg_ff <= nxt_cfg;
      chan_ff <= nxt_chan;
      start_ff <= nxt_start;
      pending_ff <= nxt_pending;
      clkSel_ff <= nxt_clkSel;
      clkTest_ff <= nxt_clkTest;
      intStatus_ff <= nxt_intStatus;
      intMask_ff <= nxt_intMask;
      resLow_ff <= nxt_resLow;
      resHigh_ff <= nxt_resHigh;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin, channel, power and interrupt outputs follow the new settings
  always_comb begin
    nxt_portB = pinMap(nxt_cfg);
    nxt_chanOut = nxt_chan;
    nxt_powerOn = (nxt_cfg != 3'h0);
    nxt_irq = nxt_intStatus && nxt_intMask;
  end

  // output registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      portB_ff <= 8'h00;
      chanOut_ff <= 3'h0;
      powerOn_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      portB_ff <= nxt_portB;
      chanOut_ff <= nxt_chanOut;
      powerOn_ff <= nxt_powerOn;
      irq_ff <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the strobe
  always_comb begin
    nxt_rdData = 8'h00;
    if (regRdEn) begin
      case (regAddr)
        asc_pkg::ASC_OFS_RES_LOW: nxt_rdData = resLow_ff;
        asc_pkg::ASC_OFS_RES_HIGH: nxt_rdData = resHigh_ff;
        asc_pkg::ASC_OFS_CTRL: nxt_rdData = {start_ff, pending_ff, cfg_ff, chan_ff};
        asc_pkg::ASC_OFS_CLKSEL: nxt_rdData = {clkTest_ff, 5'h00, clkSel_ff};
        asc_pkg::ASC_OFS_INT_STATUS: nxt_rdData = {7'h00, intStatus_ff};
        asc_pkg::ASC_OFS_INT_MASK: nxt_rdData = {7'h00, intMask_ff};
        default: nxt_rdData = 8'h00;
      endcase
    end
  end

  // read data register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= 8'h00;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  // port drivers
  assign regRdData = rdData_ff;
  assign portBAnalog = portB_ff;
  assign analogChannel = chanOut_ff;
  assign converterPowerOn = powerOn_ff;
  assign dacCode = engTrial;
  assign convIrq = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // age of the clock select setting, for the divider check
  always_comb begin
    if (wrClkSel) begin
      nxt_selAge = 4'h0;
    end else if (selAge_ff != 4'hF) begin
      nxt_selAge = selAge_ff + 4'h1;
    end else begin
      nxt_selAge = selAge_ff;
    end
  end

  // setting age register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      selAge_ff <= 4'h0;
    end else begin
      selAge_ff <= nxt_selAge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_pend_on_rise: assert property (
    startRise |=> pending_ff && $past(regWrData[7]) ##1 pending_ff || engDone
  ) else $error("pending flag not raised by start rise");

  a_pend_clr_end: assert property (
    (engDone && !startRise) |=> !pending_ff && regRdEn || !pending_ff
  ) else $error("pending flag not cleared at conversion end");

  a_irq_flag_end: assert property (
    engDone |=> intStatus_ff ##0 (convIrq == intMask_ff)
  ) else $error("interrupt flag not set at conversion end");

  a_result_justify: assert property (
    engDone |=> (resHigh_ff == $past(engResult[9:2]))
      && (resLow_ff == {$past(engResult[1:0]), 6'h00})
  ) else $error("result bytes not left justified");

  a_result_hold: assert property (
    !engDone |=> $stable(resHigh_ff) && $stable(resLow_ff)
  ) else $error("result bytes changed without a conversion end");

  a_pin_full_none: assert property (
    ((wrCtrl && regWrData[5:3] == 3'h7) |=> portBAnalog == 8'hFF)
      and ((wrCtrl && regWrData[5:3] == 3'h0) |=> portBAnalog == 8'h00)
  ) else $error("full or empty pin map wrong");

  a_pin_four_ch0: assert property (
    (wrCtrl && regWrData == 8'h20) |=> (portBAnalog == 8'h0F) && (analogChannel == 3'h0)
  ) else $error("control value 20h did not map four pins and channel zero");

  a_pin_count: assert property (
    (wrCtrl && regWrData[5:3] != 3'h7) |=>
      (portBAnalog == 8'((9'h001 << $past(regWrData[5:3])) - 9'h001))
  ) else $error("pin map does not match config code");

  a_chan_select: assert property (
    wrCtrl |=> analogChannel == $past(regWrData[2:0])
  ) else $error("channel output does not follow control write");

  a_power_down: assert property (
    (cfg_ff == 3'h0) |-> !converterPowerOn ##1 (cfg_ff != 3'h0) || !converterPowerOn
  ) else $error("converter powered with no pins configured");

  a_launch_fall: assert property (
    (startFall && powerOn_ff && !engBusy) |=> engBusy [*2]
  ) else $error("falling start edge did not launch conversion");

  a_div_eight: assert property (
    disable iff (!rst_n || wrClkSel)
    (convTick && clkSel_ff == 2'h1 && selAge_ff == 4'hF) |=> !convTick [*7] ##1 convTick
  ) else $error("select value one is not divide by eight");

endmodule

// file: testbench/asc_top_bench.sv
`timescale 1ns/1ps
module asc_top_bench;
  logic sys_clk;
  logic rst_n;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWrEn;
  logic regRdEn;
  logic [7:0] regRdData;
  logic compIn;
  logic [7:0] portBAnalog;
  logic [2:0] analogChannel;
  logic converterPowerOn;
  logic [9:0] dacCode;
  logic convIrq;
  logic rdSeen;
  logic [9:0] target;
  logic [9:0] lastRes;
  logic [31:0] lfsrState;
  logic [15:0] expQ[$];
  logic [15:0] note;
  int fail_count;
  int total_checks;
  int cyc;

  asc_top i_asc_top (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regRdData(regRdData),
    .compIn(compIn),
    .portBAnalog(portBAnalog),
    .analogChannel(analogChannel),
    .converterPowerOn(converterPowerOn),
    .dacCode(dacCode),
    .convIrq(convIrq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, cycle count, comparator model and read monitor
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // comparator: input sits half a step above target, so decisions are never ties
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    rdSeen <= regRdEn;
    compIn <= (dacCode <= target);
  end

  // read data stands only in the cycle after the strobe
  always @(negedge sys_clk) begin
    if (rdSeen === 1'b1 && expQ.size() > 0) begin
      note = expQ.pop_front();
      check("regRdData", {8'h00, regRdData & note[15:8]}, {8'h00, note[7:0] & note[15:8]});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [9:0] draw();
    lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    return lfsrState[9:0];
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask

  // m selects the bits that are compared; a zero mask just samples
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
                    output logic [7:0] v);
    @(posedge sys_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    expQ.push_back({m, e});
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    @(negedge sys_clk);
    v = regRdData;
  endtask

  // full start pulse, optional abort by a second rise, then poll and read result
  task automatic convert(input logic [7:0] ctl, input logic [1:0] div, input int divisor,
                         input logic abort);
    int t0;
    int i;
    logic [7:0] v;
    logic inTime;
    target = draw();
    wr(asc_pkg::ASC_OFS_CLKSEL, {6'h00, div});
    wr(asc_pkg::ASC_OFS_CTRL, ctl);
    wr(asc_pkg::ASC_OFS_CTRL, ctl | 8'h80);
    rd(asc_pkg::ASC_OFS_CTRL, 8'h40, 8'h40, v);
    wr(asc_pkg::ASC_OFS_CTRL, ctl);
    if (abort) begin
      repeat (100) @(posedge sys_clk);
      wr(asc_pkg::ASC_OFS_CTRL, ctl | 8'h80);
      rd(asc_pkg::ASC_OFS_CTRL, 8'h40, 8'h40, v);
      rd(asc_pkg::ASC_OFS_RES_HIGH, lastRes[9:2], 8'hFF, v);
      target = draw();
      wr(asc_pkg::ASC_OFS_CTRL, ctl);
    end
    t0 = cyc;
    v = 8'h40;
    i = 0;
    // software holds start low until pending drops
    while (v[6] !== 1'b0 && i < 3000) begin
      rd(asc_pkg::ASC_OFS_CTRL, 8'h00, 8'h00, v);
      i++;
    end
    if (i >= 3000) begin
      check("pendingTimeout", 16'h0001, 16'h0000);
      end_sim();
    end else begin
      inTime = ((cyc - t0) >= 43 * divisor) && ((cyc - t0) <= 45 * divisor + 8);
      check("convTime", {15'h0000, inTime}, 16'h0001);
      rd(asc_pkg::ASC_OFS_RES_HIGH, target[9:2], 8'hFF, v);
      rd(asc_pkg::ASC_OFS_RES_LOW, {target[1:0], 6'h00}, 8'hFF, v);
      lastRes = target;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin : mainSeq
    logic [7:0] ctl;
    logic [7:0] rv;
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    compIn = 1'b0;
    rdSeen = 1'b0;
    target = 10'h000;
    lastRes = 10'h000;
    lfsrState = 32'hE174;
    fail_count = 0;
    total_checks = 0;
    cyc = 0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values, read-only result, unmapped address
    for (int a = 36; a <= 41; a++) begin
      rd(a[7:0], 8'h00, 8'hFF, rv);
    end
    check("convIrq", {15'h0000, convIrq}, 16'h0000);
    wr(asc_pkg::ASC_OFS_RES_HIGH, 8'hFF);
    rd(asc_pkg::ASC_OFS_RES_HIGH, 8'h00, 8'hFF, rv);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00, 8'hFF, rv);
    wr(asc_pkg::ASC_OFS_CLKSEL, 8'hFF);
    rd(asc_pkg::ASC_OFS_CLKSEL, 8'h83, 8'hFF, rv);
    $display("test reset and map done");
    // every pin configuration code and channel code
    for (int c = 0; c < 8; c++) begin
      ctl = {2'b00, c[2:0], c[2:0]};
      wr(asc_pkg::ASC_OFS_CTRL, ctl | 8'h40);
      @(negedge sys_clk);
      check("portBAnalog", {8'h00, portBAnalog}, (c == 7) ? 16'h00FF : 16'((1 << c) - 1));
      check("analogChannel", {13'h0000, analogChannel}, 16'(c));
      check("converterPowerOn", {15'h0000, converterPowerOn}, 16'(c != 0));
      rd(asc_pkg::ASC_OFS_CTRL, ctl, 8'hFF, rv);
    end
    wr(asc_pkg::ASC_OFS_CTRL, 8'h20);
    @(negedge sys_clk);
    check("portBAnalog", {8'h00, portBAnalog}, 16'h000F);
    check("analogChannel", {13'h0000, analogChannel}, 16'h0000);
    $display("test pin configuration done");
    // unmasked conversion at divide by eight, interrupt set and cleared
    wr(asc_pkg::ASC_OFS_INT_MASK, 8'h01);
    convert(8'h20, asc_pkg::ASC_SEL_DIV8, 8, 1'b0);
    check("convIrq", {15'h0000, convIrq}, 16'h0001);
    rd(asc_pkg::ASC_OFS_INT_STATUS, 8'h01, 8'hFF, rv);
    wr(asc_pkg::ASC_OFS_INT_STATUS, 8'h01);
    @(negedge sys_clk);
    check("convIrq", {15'h0000, convIrq}, 16'h0000);
    // masked conversion at divide by two
    wr(asc_pkg::ASC_OFS_INT_MASK, 8'h00);
    convert(8'h3D, asc_pkg::ASC_SEL_DIV2, 2, 1'b0);
    check("convIrq", {15'h0000, convIrq}, 16'h0000);
    rd(asc_pkg::ASC_OFS_INT_STATUS, 8'h01, 8'hFF, rv);
    wr(asc_pkg::ASC_OFS_INT_MASK, 8'h01);
    @(negedge sys_clk);
    check("convIrq", {15'h0000, convIrq}, 16'h0001);
    wr(asc_pkg::ASC_OFS_INT_STATUS, 8'h01);
    $display("test conversions and interrupt done");
    // slowest clock and an abort in mid-conversion
    convert(8'h2A, asc_pkg::ASC_SEL_DIV32, 32, 1'b0);
    convert(8'h23, asc_pkg::ASC_SEL_DIV8, 8, 1'b1);
    $display("test abort done");
    // launch while powered down is ignored
    wr(asc_pkg::ASC_OFS_INT_STATUS, 8'h01);
    wr(asc_pkg::ASC_OFS_CTRL, 8'h80);
    wr(asc_pkg::ASC_OFS_CTRL, 8'h00);
    repeat (2000) @(posedge sys_clk);
    rd(asc_pkg::ASC_OFS_CTRL, 8'h40, 8'hFF, rv);
    rd(asc_pkg::ASC_OFS_INT_STATUS, 8'h00, 8'hFF, rv);
    rd(asc_pkg::ASC_OFS_RES_HIGH, lastRes[9:2], 8'hFF, rv);
    check("converterPowerOn", {15'h0000, converterPowerOn}, 16'h0000);
    $display("test power down done");
    // mid-run reset clears the held result
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(asc_pkg::ASC_OFS_RES_HIGH, 8'h00, 8'hFF, rv);
    rd(asc_pkg::ASC_OFS_RES_LOW, 8'h00, 8'hFF, rv);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
